// File: hw/pdrl_regs.sv
// Diagnostic, reset and multi-purpose LED register bank with an AXI4-Lite slave.
`default_nettype none
module pdrl_regs
    import pdrl_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Cable measurement engine.
    output logic cable_diag_run,
    input wire logic cable_diag_done,
    input wire logic cable_diag_fail,
    // Reset requests to the transceiver.
    output logic soft_reset_pulse,
    output logic digital_restart_pulse,
    // LED sources, strap and pins.
    input wire pdrl_led_in_t led_in,
    input wire pdrl_led_evt_t led_evt,
    input wire logic led_pol_strap,
    output logic first_led_pin_o,
    output logic first_led_pin_oe,
    output logic col_pin_o,
    output logic col_pin_oe,
    // Interrupt.
    output logic irq
);

    logic aw_held_r, w_held_r, ar_held_r;
    logic [7:0] waddr_r, raddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic diag_start_r, diag_done_r, diag_fail_r;
    logic soft_rst_r, dig_rst_r, strap_taken_r;
    logic led_pol_r;
    logic [3:0] led_cfg_r;
    logic [1:0] led_route_r;
    logic lost_latch_r, prbs_latch_r;
    logic [IRQ_W-1:0] irq_stat_r, irq_en_r;

    // A pending software reset returns all diagnostic, reset, LED and interrupt state to its defaults, but not the AXI channel state or the reset pulses.
    wire reg_clr = !aresetn || soft_rst_r;

    // Write decode; a write happens once both address and data are held.
    wire do_write = aw_held_r && w_held_r && !s_axi_bvalid;
    wire wr_lo = do_write && wstrb_r[0];
    wire wr_hi = do_write && wstrb_r[1];
    wire wr_diag = waddr_r == CABLE_DIAG_ADDR;
    wire wr_rstc = waddr_r == PHY_RESET_ADDR;
    wire wr_led = waddr_r == MULTI_LED_ADDR;
    wire wr_en = waddr_r == IRQ_ENABLE_ADDR;
    wire wr_clr = waddr_r == IRQ_CLEAR_ADDR;
    wire wr_known = wr_diag || wr_rstc || wr_led || wr_en || wr_clr || waddr_r == IRQ_STATUS_ADDR;

    // Cable measurement control decode.
    wire diag_wr = wr_hi && wr_diag;
    wire diag_start_wr = diag_wr && wdata_r[DIAG_START_BIT];
    wire diag_finish = diag_start_r && cable_diag_done && !diag_wr;

    // Read decode.
    wire do_read = ar_held_r && !s_axi_rvalid;
    wire [15:0] diag_view = CABLE_DIAG_RSVD | 16'({diag_start_r, 15'h0}) |
                            16'({diag_done_r, diag_fail_r});
    wire [15:0] rstc_view = 16'({soft_rst_r, dig_rst_r, 14'h0});
    wire [15:0] led_view = 16'({led_pol_r, 2'h0, led_cfg_r, 1'b0, led_route_r}) ;
    wire rd_known = raddr_r == CABLE_DIAG_ADDR || raddr_r == PHY_RESET_ADDR ||
                    raddr_r == MULTI_LED_ADDR || raddr_r == IRQ_STATUS_ADDR ||
                    raddr_r == IRQ_ENABLE_ADDR || raddr_r == IRQ_CLEAR_ADDR;
    wire [15:0] rd_sel = (raddr_r == CABLE_DIAG_ADDR) ? diag_view :
                         (raddr_r == PHY_RESET_ADDR) ? rstc_view :
                         (raddr_r == MULTI_LED_ADDR) ? led_view :
                         (raddr_r == IRQ_STATUS_ADDR) ? 16'(irq_stat_r) :
                         (raddr_r == IRQ_ENABLE_ADDR) ? 16'(irq_en_r) : 16'h0000;

    // LED source selection; the reserved code shows a dark LED.
    wire [15:0] led_src_vec = {1'b0, prbs_latch_r, lost_latch_r, led_in.mii_err, led_in.lpi,
                               led_in.mii_link, led_in.stretch, led_in.link_blink,
                               led_in.full_duplex, !led_in.speed100, led_in.speed100,
                               led_in.collision, led_in.rx_act, led_in.tx_act,
                               led_in.rx_act || led_in.tx_act, led_in.link_ok};
    wire led_src = led_src_vec[led_cfg_r];
    wire led_level = led_pol_r ? led_src : !led_src;

    // Interrupt events.
    wire [IRQ_W-1:0] irq_evt = IRQ_W'({led_evt.link_lost, diag_finish && cable_diag_fail, diag_finish});
    wire [IRQ_W-1:0] irq_clr = (wr_lo && wr_clr) ? wdata_r[IRQ_W-1:0] : '0;

    // Write address and data are caught independently, in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            waddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                waddr_r <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Write response is raised on the same edge that applies the write.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Each ready is offered only while its own channel holds nothing and no response is pending, so one write is in flight.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            s_axi_arready <= !ar_held_r && !(s_axi_arvalid && s_axi_arready) && !s_axi_rvalid;
        end
    end

    // Read address capture and data return.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_held_r <= 1'b0;
            raddr_r <= '0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                ar_held_r <= 1'b1;
                raddr_r <= s_axi_araddr;
            end else if (do_read) begin
                ar_held_r <= 1'b0;
            end
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= 32'(rd_sel);
                s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Cable measurement start, completion and failure flags.
    always_ff @(posedge aclk) begin
        if (reg_clr) begin
            diag_start_r <= 1'b0;
            diag_done_r <= DIAG_DONE_RST;
            diag_fail_r <= DIAG_FAIL_RST;
        end else if (diag_wr) begin
            diag_start_r <= wdata_r[DIAG_START_BIT];
            if (diag_start_wr) begin
                diag_done_r <= 1'b0;
                diag_fail_r <= 1'b0;
            end
        end else if (diag_finish) begin
            diag_start_r <= 1'b0;
            diag_done_r <= 1'b1;
            diag_fail_r <= cable_diag_fail;
        end
    end

    // Self-clearing reset bits live one cycle, then fire their pulse.
    always_ff @(posedge aclk) begin
        if (reg_clr) begin
            soft_rst_r <= 1'b0;
            dig_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= wr_hi && wr_rstc && wdata_r[SOFT_RESET_BIT];
            dig_rst_r <= wr_hi && wr_rstc && wdata_r[DIG_RESTART_BIT];
        end
    end

    // Reset pulses; the digital restart leaves every register here alone.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_reset_pulse <= 1'b0;
            digital_restart_pulse <= 1'b0;
        end else begin
            soft_reset_pulse <= soft_rst_r;
            digital_restart_pulse <= dig_rst_r;
        end
    end

    // Polarity is taken from the inverted strap on the first clock after a hardware or software reset.
    always_ff @(posedge aclk) begin
        if (reg_clr) begin
            strap_taken_r <= 1'b0;
            led_pol_r <= 1'b0;
            led_cfg_r <= LED_CFG_RST;
            led_route_r <= LED_ROUTE_RST;
        end else begin
            strap_taken_r <= 1'b1;
            if (!strap_taken_r) begin
                led_pol_r <= !led_pol_strap;
            end else if (wr_hi && wr_led) begin
                led_pol_r <= wdata_r[LED_POL_BIT];
            end
            if (wr_lo && wr_led) begin
                led_cfg_r <= wdata_r[LED_CFG_LSB +: 4];
                led_route_r <= wdata_r[LED_ROUTE_LSB +: 2];
            end
        end
    end

    // Sticky LED latches; a new event wins over the clearing action.
    always_ff @(posedge aclk) begin
        if (reg_clr) begin
            lost_latch_r <= 1'b0;
            prbs_latch_r <= 1'b0;
        end else begin
            lost_latch_r <= led_evt.link_lost || (lost_latch_r && !led_evt.basic_status_read);
            prbs_latch_r <= led_evt.prbs_err || (prbs_latch_r && !led_evt.selftest_error_clear);
        end
    end

    // LED pin drive; a reserved route code leaves both pins undriven.
    always_ff @(posedge aclk) begin
        if (reg_clr) begin
            col_pin_oe <= 1'b0;
            col_pin_o <= 1'b0;
            first_led_pin_oe <= 1'b0;
            first_led_pin_o <= 1'b0;
        end else begin
            col_pin_oe <= led_route_r == ROUTE_COL;
            col_pin_o <= led_level;
            first_led_pin_oe <= led_route_r == ROUTE_FIRST_LED;
            first_led_pin_o <= led_level;
        end
    end

    // Interrupt status, enable and output; set wins over a same-cycle clear.
    always_ff @(posedge aclk) begin
        if (reg_clr) begin
            irq_stat_r <= '0;
            irq_en_r <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat_r <= irq_evt | (irq_stat_r & ~irq_clr);
            if (wr_lo && wr_en) begin
                irq_en_r <= wdata_r[IRQ_W-1:0];
            end
            irq <= |(irq_stat_r & irq_en_r);
        end
    end

    // The engine runs while the start bit stands.
    assign cable_diag_run = diag_start_r;

    // Checks.
    property p_diag_start;
        @(posedge aclk) disable iff (!aresetn)
        diag_start_wr && !soft_rst_r |=> diag_start_r && !diag_done_r;
    endproperty
    a_diag_start: assert property (p_diag_start) else $error("start write did not start");

    property p_diag_clear;
        @(posedge aclk) disable iff (!aresetn)
        $rose(diag_done_r) |-> !diag_start_r;
    endproperty
    a_diag_clear: assert property (p_diag_clear) else $error("start not cleared at done");

    property p_diag_done;
        @(posedge aclk) disable iff (!aresetn)
        diag_finish && !soft_rst_r |=> diag_done_r && (diag_fail_r == $past(cable_diag_fail));
    endproperty
    a_diag_done: assert property (p_diag_done) else $error("done or fail flag wrong");

    property p_fail_rst;
        @(posedge aclk) $fell(aresetn) |=> diag_done_r && !diag_fail_r;
    endproperty
    a_fail_rst: assert property (p_fail_rst) else $error("diag flags wrong after reset");

    property p_soft_reset;
        @(posedge aclk) disable iff (!aresetn)
        soft_rst_r |=> soft_reset_pulse && !soft_rst_r && led_cfg_r == LED_CFG_RST ##1 !soft_reset_pulse;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("software reset misbehaved");

    property p_restart;
        @(posedge aclk) disable iff (!aresetn)
        dig_rst_r && !soft_rst_r |=> digital_restart_pulse && !dig_rst_r && $stable(led_cfg_r);
    endproperty
    a_restart: assert property (p_restart) else $error("digital restart misbehaved");

    property p_strap;
        @(posedge aclk) disable iff (!aresetn)
        !strap_taken_r && !soft_rst_r |=> led_pol_r == !$past(led_pol_strap);
    endproperty
    a_strap: assert property (p_strap) else $error("polarity not from strap");

    property p_lost;
        @(posedge aclk) disable iff (!aresetn)
        led_evt.link_lost && !soft_rst_r |=> lost_latch_r;
    endproperty
    a_lost: assert property (p_lost) else $error("link lost not latched");

    property p_prbs;
        @(posedge aclk) disable iff (!aresetn)
        prbs_latch_r && !led_evt.selftest_error_clear && !soft_rst_r |=> prbs_latch_r;
    endproperty
    a_prbs: assert property (p_prbs) else $error("prbs latch dropped early");

    property p_route;
        @(posedge aclk) disable iff (!aresetn)
        !soft_rst_r |=> (col_pin_oe == ($past(led_route_r) == ROUTE_COL)) && !(col_pin_oe && first_led_pin_oe);
    endproperty
    a_route: assert property (p_route) else $error("LED route wrong");

    property p_selfclear;
        @(posedge aclk) disable iff (!aresetn)
        soft_rst_r || dig_rst_r |=> !soft_rst_r && !dig_rst_r;
    endproperty
    a_selfclear: assert property (p_selfclear) else $error("reset bits stuck");

    c_diag: cover property (@(posedge aclk) disable iff (!aresetn) diag_finish && cable_diag_fail);
    c_soft: cover property (@(posedge aclk) disable iff (!aresetn) soft_reset_pulse);
    c_led: cover property (@(posedge aclk) disable iff (!aresetn) first_led_pin_oe && lost_latch_r);
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);

endmodule
`default_nettype wire

// File: inc/pdrl_pkg.sv
// Package of register map, field positions and types for the diagnostic/reset/LED register bank.
`default_nettype none
package pdrl_pkg;
    // Register indices; each byte address is four times its index.
    localparam logic [7:0] CABLE_DIAG_IDX = 8'h1e;
    localparam logic [7:0] PHY_RESET_IDX = 8'h1f;
    localparam logic [7:0] MULTI_LED_IDX = 8'h25;
    localparam logic [7:0] IRQ_STATUS_IDX = 8'h30;
    localparam logic [7:0] IRQ_ENABLE_IDX = 8'h31;
    localparam logic [7:0] IRQ_CLEAR_IDX = 8'h32;
    localparam logic [7:0] CABLE_DIAG_ADDR = 8'(CABLE_DIAG_IDX * 4);
    localparam logic [7:0] PHY_RESET_ADDR = 8'(PHY_RESET_IDX * 4);
    localparam logic [7:0] MULTI_LED_ADDR = 8'(MULTI_LED_IDX * 4);
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'(IRQ_STATUS_IDX * 4);
    localparam logic [7:0] IRQ_ENABLE_ADDR = 8'(IRQ_ENABLE_IDX * 4);
    localparam logic [7:0] IRQ_CLEAR_ADDR = 8'(IRQ_CLEAR_IDX * 4);
    // Field positions.
    localparam int DIAG_START_BIT = 15;
    localparam int DIAG_DONE_BIT = 1;
    localparam int DIAG_FAIL_BIT = 0;
    localparam int SOFT_RESET_BIT = 15;
    localparam int DIG_RESTART_BIT = 14;
    localparam int LED_POL_BIT = 9;
    localparam int LED_CFG_LSB = 3;
    localparam int LED_ROUTE_LSB = 0;
    // Reset values.
    localparam logic [15:0] CABLE_DIAG_RSVD = 16'h0100;
    localparam logic DIAG_DONE_RST = 1'b1;
    localparam logic DIAG_FAIL_RST = 1'b0;
    localparam logic [3:0] LED_CFG_RST = 4'h0;
    localparam logic [1:0] LED_ROUTE_RST = 2'h0;
    // Route codes.
    localparam logic [1:0] ROUTE_COL = 2'h0;
    localparam logic [1:0] ROUTE_FIRST_LED = 2'h3;
    // Interrupt status bits.
    localparam int IRQ_W = 3;
    localparam int IRQ_DIAG_DONE = 0;
    localparam int IRQ_DIAG_FAIL = 1;
    localparam int IRQ_LINK_LOST = 2;
    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // LED source codes.
    typedef enum logic [3:0] {
        LED_LINK_OK, LED_ACT, LED_TX_ACT, LED_RX_ACT, LED_COLLISION, LED_SPEED100,
        LED_SPEED10, LED_FULL_DUPLEX, LED_LINK_BLINK, LED_STRETCH, LED_MII_LINK,
        LED_LPI, LED_MII_ERR, LED_LINK_LOST, LED_PRBS_ERR, LED_RESERVED
    } pdrl_led_src_t;
    // Live status inputs from the transceiver that feed the LED.
    typedef struct packed {
        logic link_ok;
        logic rx_act;
        logic tx_act;
        logic collision;
        logic speed100;
        logic full_duplex;
        logic link_blink;
        logic stretch;
        logic mii_link;
        logic lpi;
        logic mii_err;
    } pdrl_led_in_t;
    // Event pulses from the rest of the transceiver.
    typedef struct packed {
        logic link_lost;
        logic prbs_err;
        logic basic_status_read;
        logic selftest_error_clear;
    } pdrl_led_evt_t;
endpackage
`default_nettype wire

// File: dv/pdrl_regs_tb.sv
// Self-checking testbench for the diagnostic, reset and LED register bank.
`default_nettype none
module pdrl_regs_tb import pdrl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    // Bus, clock and reset signals.
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr, araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    // Transceiver side signals.
    logic run, done_i, fail_i, soft_p, dig_p, strap, irq;
    logic led_o, led_oe, col_o, col_oe;
    pdrl_led_in_t led_in;
    pdrl_led_evt_t led_evt;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int n_soft = 0;
    int n_dig = 0;
    // Input pattern for each source code 0 to 12 that lights that code; code 6 is lit by the complement instead.
    logic [10:0] src_mask [13] = '{11'h400, 11'h300, 11'h100, 11'h200, 11'h080, 11'h040, 11'h040,
                                   11'h020, 11'h010, 11'h008, 11'h004, 11'h002, 11'h001};

    pdrl_regs DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cable_diag_run(run), .cable_diag_done(done_i), .cable_diag_fail(fail_i),
        .soft_reset_pulse(soft_p), .digital_restart_pulse(dig_p),
        .led_in(led_in), .led_evt(led_evt), .led_pol_strap(strap),
        .first_led_pin_o(led_o), .first_led_pin_oe(led_oe), .col_pin_o(col_o), .col_pin_oe(col_oe),
        .irq(irq)
    );

    // Clock of 100 ns period.
    always #50 aclk = ~aclk;

    // Cycle count for the hang limit, and counts of reset request pulses seen.
    always @(posedge aclk) begin
        cyc = cyc + 1;
        if (aresetn) begin
            n_soft = n_soft + int'(soft_p);
            n_dig = n_dig + int'(dig_p);
        end
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            close_out();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Compares a seen value against the expected one.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // One write; address and data are offered together and each is released when taken.
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        bit aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    // One read; rready is held until the data arrive.
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axw(a, d, r);
        chk(32'(r), 32'(RESP_OKAY));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axr(a, d, r);
        chk(32'(r), 32'(RESP_OKAY));
        chk(d, exp);
    endtask

    // One-cycle event pulse, then time for the pin to follow.
    task automatic pulse(input logic [3:0] e);
        led_evt <= e;
        @(posedge aclk);
        led_evt <= 4'h0;
        ticks(3);
    endtask

    // Main sequence; inputs change only by non-blocking assignment after an edge.
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} <= '0;
        {done_i, fail_i, led_in, led_evt} <= '0;
        wstrb <= 4'hf;
        strap <= 1'b1;
        ticks(6);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(CABLE_DIAG_ADDR, 32'h0000_0102);
        rd(PHY_RESET_ADDR, 32'h0000_0000);
        rd(MULTI_LED_ADDR, 32'h0000_0000);
        // A failing measurement raises the enabled interrupt.
        wr(IRQ_ENABLE_ADDR, 32'h0000_0001);
        wr(CABLE_DIAG_ADDR, 32'h0000_8000);
        chk(32'(run), 32'h1);
        rd(CABLE_DIAG_ADDR, 32'h0000_8100);
        fail_i <= 1'b1;
        done_i <= 1'b1;
        @(posedge aclk);
        done_i <= 1'b0;
        ticks(3);
        chk(32'(run), 32'h0);
        chk(32'(irq), 32'h1);
        // Software waits for completion before it trusts the failure flag.
        do axr(CABLE_DIAG_ADDR, d, r); while (!d[DIAG_DONE_BIT]);
        rd(CABLE_DIAG_ADDR, 32'h0000_0103);
        rd(IRQ_STATUS_ADDR, 32'h0000_0003);
        wr(IRQ_CLEAR_ADDR, 32'h0000_0003);
        rd(IRQ_STATUS_ADDR, 32'h0000_0000);
        chk(32'(irq), 32'h0);
        // A passing run with the interrupt masked, then a start and a stop.
        wr(IRQ_ENABLE_ADDR, 32'h0000_0000);
        fail_i <= 1'b0;
        wr(CABLE_DIAG_ADDR, 32'h0000_8000);
        rd(CABLE_DIAG_ADDR, 32'h0000_8100);
        done_i <= 1'b1;
        @(posedge aclk);
        done_i <= 1'b0;
        ticks(3);
        rd(CABLE_DIAG_ADDR, 32'h0000_0102);
        chk(32'(irq), 32'h0);
        wr(IRQ_CLEAR_ADDR, 32'h0000_0003);
        wr(CABLE_DIAG_ADDR, 32'h0000_8000);
        wr(CABLE_DIAG_ADDR, 32'h0000_0000);
        chk(32'(run), 32'h0);
        // Digital restart keeps the registers; software reset restores them and retakes the strap.
        wr(MULTI_LED_ADDR, 32'h0000_021b);
        wr(PHY_RESET_ADDR, 32'h0000_4000);
        ticks(3);
        chk(32'(n_dig), 32'h1);
        rd(PHY_RESET_ADDR, 32'h0000_0000);
        rd(MULTI_LED_ADDR, 32'h0000_021b);
        strap <= 1'b0;
        wr(PHY_RESET_ADDR, 32'h0000_8000);
        ticks(3);
        chk(32'(n_soft), 32'h1);
        rd(PHY_RESET_ADDR, 32'h0000_0000);
        rd(MULTI_LED_ADDR, 32'h0000_0200);
        rd(CABLE_DIAG_ADDR, 32'h0000_0102);
        // Every live source code on the first LED pin, active high.
        for (int c = 0; c < 13; c++) begin
            wr(MULTI_LED_ADDR, 32'h0000_0203 | (32'(c) << 3));
            led_in <= pdrl_led_in_t'(src_mask[c]);
            ticks(3);
            chk(32'(led_o), (c == 6) ? 32'h0 : 32'h1);
            led_in <= pdrl_led_in_t'(~src_mask[c]);
            ticks(3);
            chk(32'(led_o), (c == 6) ? 32'h1 : 32'h0);
        end
        chk(32'({led_oe, col_oe}), 32'h2);
        wr(MULTI_LED_ADDR, 32'h0000_027b);
        led_in <= '1;
        ticks(3);
        chk(32'(led_o), 32'h0);
        // Active low on the collision pin, then a reserved route drives neither pin.
        wr(MULTI_LED_ADDR, 32'h0000_0000);
        ticks(3);
        chk(32'({led_oe, col_oe, col_o}), 32'h2);
        led_in <= '0;
        ticks(3);
        chk(32'(col_o), 32'h1);
        wr(MULTI_LED_ADDR, 32'h0000_0001);
        ticks(3);
        chk(32'({led_oe, col_oe}), 32'h0);
        // Only the high byte lane is written: polarity changes, source and route stay.
        wstrb <= 4'h2;
        wr(MULTI_LED_ADDR, 32'h0000_02ff);
        wstrb <= 4'hf;
        rd(MULTI_LED_ADDR, 32'h0000_0201);
        // Link-lost latch held until the basic status read, with its interrupt.
        wr(IRQ_ENABLE_ADDR, 32'h0000_0004);
        wr(MULTI_LED_ADDR, 32'h0000_026b);
        pulse(4'h8);
        ticks(5);
        chk(32'({led_o, irq}), 32'h3);
        pulse(4'h2);
        chk(32'(led_o), 32'h0);
        wr(IRQ_CLEAR_ADDR, 32'h0000_0004);
        chk(32'(irq), 32'h0);
        // Checker error latch held until the self-test status is cleared.
        wr(MULTI_LED_ADDR, 32'h0000_0273);
        pulse(4'h4);
        ticks(5);
        chk(32'(led_o), 32'h1);
        pulse(4'h1);
        chk(32'(led_o), 32'h0);
        // An unmapped address is refused on both paths.
        axr(8'h40, d, r);
        chk(32'(r), 32'(RESP_SLVERR));
        chk(d, 32'h0);
        axw(8'h40, 32'h0000_ffff, r);
        chk(32'(r), 32'(RESP_SLVERR));
        close_out();
    end
endmodule
`default_nettype wire
